// *** hw/dab_pkg.sv ***
// Package with shared types and constants of the integer datapath step block.
package dab_pkg;

  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int DATA_W = 32;
  localparam int RC_W = 32;
  localparam int IFLAG_W = 8;
  localparam int EXT_EXTERNAL_INTERRUPT_TWO_BIT = 2;
  localparam logic [7:0] WAIT_DONE_CYCLES = 8'h01;

  // ****************************************
  // APB register offsets
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OPA = 8'h04;
  localparam logic [7:0] REG_OPB = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0c;
  localparam logic [7:0] REG_FLAGS = 8'h10;
  localparam logic [7:0] REG_IFLAG = 8'h14;
  localparam logic [7:0] REG_IMASK = 8'h18;
  localparam logic [7:0] REG_RCOUNT = 8'h1c;
  localparam logic [7:0] REG_AUX0 = 8'h20;
  localparam logic [7:0] REG_INDEX0 = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;
  localparam logic [7:0] REG_CALLTGT = 8'h2c;
  localparam logic [7:0] REG_RESUME = 8'h30;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] PSLVERR_NONE = 32'h0000_0000;

  // ****************************************
  // Operation codes written to the control register
  // ****************************************
  typedef enum logic [3:0] {
    OP_NOP = 4'b0000,
    OP_AND = 4'b0001,
    OP_OR = 4'b0010,
    OP_NOT = 4'b0011,
    OP_AND_WITH_COMPLEMENT_OP = 4'b0100,
    OP_XOR = 4'b0101,
    OP_LSH = 4'b0110,
    OP_BIT_TEST = 4'b0111,
    OP_LOAD_IF_LESS = 4'b1000,
    OP_COND_SUB = 4'b1001,
    OP_BITREV_STEP = 4'b1010,
    OP_REG_CALL = 4'b1011,
    OP_WAIT_INT = 4'b1100
  } dab_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_WAIT = 2'b10
  } dab_state_e;

  // ****************************************
  // Condition flags
  // ****************************************
  typedef struct packed {
    logic neg;
    logic zero;
  } dab_flags_s;

  // ****************************************
  // APB request and answer
  // ****************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } dab_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dab_apb_rsp_s;

endpackage : dab_pkg

// *** hw/dab_alu.sv ***
// Combinational logic unit of the integer datapath step block.
`timescale 1ns/1ps
module dab_alu
(
  // Operation select
  input wire dab_pkg::dab_op_e op,
  // Operands
  input wire logic [31:0] opa,
  input wire logic [31:0] opb,
  input wire logic [31:0] dest_old,
  input wire dab_pkg::dab_flags_s flags_in,
  // Results
  output logic [31:0] result,
  output logic write_en,
  output logic flags_upd,
  output dab_pkg::dab_flags_s flags_out
);

  logic [31:0] diff;
  logic [31:0] rev_a;
  logic [31:0] rev_b;
  logic [31:0] rev_sum;

  // Reverses the bit order of a word.
  function automatic logic [31:0] bit_rev(input logic [31:0] v);
    logic [31:0] r;
    r = '0;
    for (int k = 0; k < 32; k++)
    begin
      r[k] = v[31 - k];
    end
    return r;
  endfunction : bit_rev

  always_comb
  begin
    diff = opb - opa;
    rev_a = bit_rev(opa);
    rev_b = bit_rev(opb);
    rev_sum = rev_a + rev_b;
    result = dest_old;
    write_en = 1'b1;
    flags_upd = 1'b1;
    case (op)
      dab_pkg::OP_AND: result = opa & opb;
      dab_pkg::OP_OR: result = opa | opb;
      dab_pkg::OP_NOT: result = ~opa;
      dab_pkg::OP_AND_WITH_COMPLEMENT_OP: result = opb & ~opa;
      dab_pkg::OP_XOR: result = opa ^ opb;
      dab_pkg::OP_LSH: result = opb << opa[4:0];
      dab_pkg::OP_BIT_TEST:
      begin
        result = opa & opb;
        write_en = 1'b0;
      end
      dab_pkg::OP_LOAD_IF_LESS:
      begin
        result = flags_in.neg ? opa : dest_old;
        write_en = flags_in.neg;
        flags_upd = 1'b0;
      end
      dab_pkg::OP_COND_SUB:
      begin
        if (diff[31])
        begin
          result = {opb[30:0], 1'b0};
        end
        else
        begin
          result = {diff[30:0], 1'b1};
        end
        flags_upd = 1'b0;
      end
      dab_pkg::OP_BITREV_STEP:
      begin
        result = bit_rev(rev_sum);
        flags_upd = 1'b0;
      end
      default:
      begin
        write_en = 1'b0;
        flags_upd = 1'b0;
      end
    endcase
    flags_out.zero = (result == 32'h0000_0000);
    flags_out.neg = result[31];
  end

endmodule : dab_alu

// *** hw/dab_core.sv ***
// Top of the integer datapath step block with its APB register file.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Functional notes
// - Bit test sets flags, stores nothing.
// - Requests latch even with enable clear.
// - External interrupt two sets flag bit 2.
// - Wait halts until interrupt, then resumes.
// - Repeat count N executes N plus one.
// - Load-if-less writes only when negative.
// - Provide AND, OR, NOT, AND_WITH_COMPLEMENT_OP, XOR, left shift.
// - Bit-reversed add with reversed carry.
// - Non-negative difference: shift, set one.
// - Negative difference: shift dividend, zero.
// - Repeats leave quotient low, remainder high.
// - Register call takes target from register.
// - Integer operations are 32 bits wide.
module dab_core
#(
  parameter int IFLAG_W = dab_pkg::IFLAG_W
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // APB slave
  input wire dab_pkg::dab_apb_req_s apb_req,
  output dab_pkg::dab_apb_rsp_s apb_rsp,
  // Interrupt request inputs
  input wire logic [IFLAG_W-1:0] int_req,
  // Status outputs
  output logic halted,
  output logic irq
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    dab_pkg::dab_state_e state;
    dab_pkg::dab_op_e op;
    logic global_interrupt_enable;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] result;
    dab_pkg::dab_flags_s flags;
    logic [IFLAG_W-1:0] iflag;
    logic [IFLAG_W-1:0] imask;
    logic [31:0] rcount;
    logic [31:0] aux0;
    logic [31:0] index0;
    logic [31:0] call_tgt;
    logic [31:0] resume;
    logic [31:0] exec_count;
    logic pready;
    logic [31:0] prdata;
    logic halted;
    logic irq;
  } dab_state_s;

  dab_state_s st_reg;
  dab_state_s st_next;

  logic [31:0] alu_res;
  logic alu_we;
  logic alu_fu;
  dab_pkg::dab_flags_s alu_flags;
  logic [31:0] alu_a;
  logic [31:0] alu_b;
  logic apb_wr;
  logic apb_rd;
  logic int_any;

  // ****************************************
  // Logic unit
  // ****************************************
  dab_alu u_alu
  (
    .op(st_reg.op),
    .opa(alu_a),
    .opb(alu_b),
    .dest_old(st_reg.result),
    .flags_in(st_reg.flags),
    .result(alu_res),
    .write_en(alu_we),
    .flags_upd(alu_fu),
    .flags_out(alu_flags)
  );

  // ****************************************
  // Operand routing
  // ****************************************
  always_comb
  begin
    alu_a = st_reg.opa;
    alu_b = st_reg.opb;
    if (st_reg.op == dab_pkg::OP_BITREV_STEP)
    begin
      alu_a = st_reg.index0;
      alu_b = st_reg.aux0;
    end
    else if (st_reg.op == dab_pkg::OP_COND_SUB)
    begin
      // Quotient shifts in low
      // Dividend iterates in the result register.
      alu_b = st_reg.result;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    st_next = st_reg;
    apb_wr = apb_req.psel && apb_req.penable && apb_req.pwrite && st_reg.pready;
    apb_rd = apb_req.psel && apb_req.penable && !apb_req.pwrite && st_reg.pready;
    st_next.pready = apb_req.psel && !apb_req.penable;
    int_any = |int_req;

    case (st_reg.state)
      dab_pkg::ST_EXEC:
      begin
        if (alu_fu)
        begin
          st_next.flags = alu_flags;
        end
        if (st_reg.op == dab_pkg::OP_BITREV_STEP)
        begin
          st_next.aux0 = alu_res;
        end
        else if (alu_we)
        begin
          st_next.result = alu_res;
        end
        if (st_reg.op == dab_pkg::OP_REG_CALL)
        begin
          st_next.call_tgt = st_reg.opa;
        end
        st_next.exec_count = st_reg.exec_count + 32'h0000_0001;
        if (st_reg.rcount == 32'h0000_0000)
        begin
          st_next.state = dab_pkg::ST_IDLE;
        end
        else
        begin
          st_next.rcount = st_reg.rcount - 32'h0000_0001;
        end
      end
      dab_pkg::ST_WAIT:
      begin
        if (int_any)
        begin
          st_next.state = dab_pkg::ST_IDLE;
          st_next.halted = 1'b0;
          st_next.resume = st_reg.resume + {24'h00_0000, dab_pkg::WAIT_DONE_CYCLES};
        end
      end
      default:
      begin
        st_next.state = dab_pkg::ST_IDLE;
      end
    endcase

    // ****************************************
    // Register writes
    // ****************************************
    if (apb_wr)
    begin
      case (apb_req.paddr)
        dab_pkg::REG_CTRL:
        begin
          st_next.global_interrupt_enable = apb_req.pwdata[4];
          if (apb_req.pwdata[3:0] != 4'h0 && st_reg.state == dab_pkg::ST_IDLE)
          begin
            st_next.op = dab_pkg::dab_op_e'(apb_req.pwdata[3:0]);
            st_next.exec_count = 32'h0000_0000;
            if (apb_req.pwdata[3:0] == dab_pkg::OP_WAIT_INT)
            begin
              st_next.state = dab_pkg::ST_WAIT;
              st_next.halted = 1'b1;
            end
            else
            begin
              st_next.state = dab_pkg::ST_EXEC;
            end
          end
        end
        dab_pkg::REG_OPA: st_next.opa = apb_req.pwdata;
        dab_pkg::REG_OPB: st_next.opb = apb_req.pwdata;
        dab_pkg::REG_RESULT: st_next.result = apb_req.pwdata;
        dab_pkg::REG_FLAGS: st_next.flags = apb_req.pwdata[1:0];
        dab_pkg::REG_IFLAG: st_next.iflag = st_reg.iflag & ~apb_req.pwdata[IFLAG_W-1:0];
        dab_pkg::REG_IMASK: st_next.imask = apb_req.pwdata[IFLAG_W-1:0];
        dab_pkg::REG_RCOUNT: st_next.rcount = apb_req.pwdata;
        dab_pkg::REG_AUX0: st_next.aux0 = apb_req.pwdata;
        dab_pkg::REG_INDEX0: st_next.index0 = apb_req.pwdata;
        dab_pkg::REG_RESUME: st_next.resume = apb_req.pwdata;
        default:
        begin
          st_next.op = st_next.op;
        end
      endcase
    end

    st_next.iflag = st_next.iflag | int_req;
    st_next.irq = st_reg.global_interrupt_enable && (|(st_reg.iflag & st_reg.imask));

    // ****************************************
    // Register reads
    // ****************************************
    if (apb_req.psel && !apb_req.penable)
    begin
      case (apb_req.paddr)
        dab_pkg::REG_CTRL: st_next.prdata = {27'h000_0000, st_reg.global_interrupt_enable, st_reg.op};
        dab_pkg::REG_OPA: st_next.prdata = st_reg.opa;
        dab_pkg::REG_OPB: st_next.prdata = st_reg.opb;
        dab_pkg::REG_RESULT: st_next.prdata = st_reg.result;
        dab_pkg::REG_FLAGS: st_next.prdata = {30'h0000_0000, st_reg.flags};
        dab_pkg::REG_IFLAG: st_next.prdata = 32'(st_reg.iflag);
        dab_pkg::REG_IMASK: st_next.prdata = 32'(st_reg.imask);
        dab_pkg::REG_RCOUNT: st_next.prdata = st_reg.rcount;
        dab_pkg::REG_AUX0: st_next.prdata = st_reg.aux0;
        dab_pkg::REG_INDEX0: st_next.prdata = st_reg.index0;
        dab_pkg::REG_STATUS: st_next.prdata = {st_reg.exec_count[29:0], st_reg.state};
        dab_pkg::REG_CALLTGT: st_next.prdata = st_reg.call_tgt;
        dab_pkg::REG_RESUME: st_next.prdata = st_reg.resume;
        default: st_next.prdata = dab_pkg::RESET_WORD;
      endcase
    end
    else if (apb_rd)
    begin
      st_next.prdata = dab_pkg::RESET_WORD;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign apb_rsp.pready = st_reg.pready;
  assign apb_rsp.pslverr = 1'b0;
  assign apb_rsp.prdata = st_reg.prdata;
  assign halted = st_reg.halted;
  assign irq = st_reg.irq;

endmodule : dab_core

// *** test/dab_int_src.sv ***
// Model of the interrupt sources that feed the step block.
`timescale 1ns/1ps
module dab_int_src
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // One-cycle command and request levels
  input wire logic [7:0] fire,
  output logic [7:0] int_req
);
  // ****************************************
  // Request hold
  // ****************************************
  logic [1:0] hold_reg;
  // Each request level stands three cycles, then drops.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      int_req <= 8'h00;
      hold_reg <= 2'h0;
    end
    else if (fire != 8'h00)
    begin
      int_req <= fire;
      hold_reg <= 2'h2;
    end
    else if (hold_reg != 2'h0)
      hold_reg <= hold_reg - 2'h1;
    else
      int_req <= 8'h00;
  end
endmodule : dab_int_src

// *** test/dab_core_sva.sv ***
// Checker of bus and wait timing at the ports of the step block.
`timescale 1ns/1ps
module dab_core_sva
#(
  parameter int IFLAG_W = dab_pkg::IFLAG_W
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Watched ports
  input wire dab_pkg::dab_apb_req_s apb_req,
  input wire dab_pkg::dab_apb_rsp_s apb_rsp,
  input wire logic [IFLAG_W-1:0] int_req,
  input wire logic halted,
  input wire logic irq
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_access;
    apb_req.psel && apb_req.penable && apb_rsp.pready;
  endsequence
  property p_rdy_next; s_setup |=> apb_rsp.pready; endproperty
  a_rdy_next: assert property (p_rdy_next) else $error("No ready after setup.");
  property p_rdy_once; s_access |=> !apb_rsp.pready; endproperty
  a_rdy_once: assert property (p_rdy_once) else $error("Ready held too long.");
  property p_rdy_phase; apb_rsp.pready |-> apb_req.psel && apb_req.penable; endproperty
  a_rdy_phase: assert property (p_rdy_phase) else $error("Ready outside access.");
  property p_no_err; apb_rsp.pready |-> !apb_rsp.pslverr; endproperty
  a_no_err: assert property (p_no_err) else $error("Error response seen.");
  property p_unmapped;
    s_access ##0 (!apb_req.pwrite && apb_req.paddr > dab_pkg::REG_RESUME)
      |-> apb_rsp.prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero.");
  property p_wait_hold; halted && int_req == '0 |=> halted; endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("Wait left early.");
  property p_wake_cause; $fell(halted) |-> $past(int_req) != '0; endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("Wake without request.");
  property p_wake_time; halted && int_req != '0 |-> ##[1:2] !halted; endproperty
  a_wake_time: assert property (p_wake_time) else $error("Wake too late.");
endmodule : dab_core_sva
bind dab_core dab_core_sva #(.IFLAG_W(IFLAG_W)) sva_u (.clk_sys(clk_sys), .reset(reset),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .int_req(int_req), .halted(halted), .irq(irq));

// *** test/tb_dsp_alu_divide_step_and_bitrev.sv ***
// Testbench of the step block driven over its register bus.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin \
    checks++; \
    if ((gt) !== (ex)) \
    begin \
      $display("Error %s expected %h seen %h", nm, ex, gt); \
      n_fail++; \
    end \
  end
module tb_dsp_alu_divide_step_and_bitrev;
  logic clk_sys;
  logic reset;
  dab_pkg::dab_apb_req_s apb_req;
  dab_pkg::dab_apb_rsp_s apb_rsp;
  logic [7:0] int_req;
  logic [7:0] fire;
  logic halted;
  logic irq;
  logic [31:0] rd;
  logic [31:0] ex;
  logic [31:0] q;
  logic [31:0] dd [2] = '{32'h21, 32'h3e8};
  logic [31:0] dr [2] = '{32'h5, 32'h7};
  int sh [2] = '{3, 7};
  int i;
  int n_fail;
  int checks;
  dab_core dut_u (.clk_sys(clk_sys), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .int_req(int_req), .halted(halted), .irq(irq));
  dab_int_src src_u (.clk_sys(clk_sys), .reset(reset), .fire(fire), .int_req(int_req));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic stall();
    $display("Error wait expected done seen timeout");
    n_fail++;
    test_done();
  endtask : stall
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    apb_req <= '{1'h1, 1'h0, w, ad, d};
    @(posedge clk_sys);
    apb_req.penable <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (apb_rsp.pready !== 1'h1 && n < 20);
    rd = apb_rsp.prdata;
    apb_req.psel <= 1'h0;
    apb_req.penable <= 1'h0;
    if (n >= 20)
      stall();
    @(posedge clk_sys);
  endtask : xfer
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    xfer(1'h1, ad, d);
  endtask : wr
  task automatic rdchk(input string nm, input logic [7:0] ad, input logic [31:0] e);
    xfer(1'h0, ad, 32'h0);
    `CHK(nm, e, rd)
  endtask : rdchk
  task automatic run_op(input logic [3:0] op, input logic [31:0] cnt);
    int n;
    n = 0;
    wr(dab_pkg::REG_RCOUNT, cnt);
    wr(dab_pkg::REG_CTRL, {28'h0, op});
    do
    begin
      xfer(1'h0, dab_pkg::REG_STATUS, 32'h0);
      n++;
    end
    while (rd[1:0] !== 2'h0 && n < 600);
    if (n >= 600)
      stall();
  endtask : run_op
  function automatic logic [31:0] ref_op(input int op, input logic [31:0] a,
    input logic [31:0] b);
    case (op)
      1: return a & b;
      2: return a | b;
      3: return ~a;
      4: return b & ~a;
      5: return a ^ b;
      default: return b << a[4:0];
    endcase
  endfunction : ref_op
  function automatic logic [31:0] rc_add(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] s;
    s = {<<{a}} + {<<{b}};
    return {<<{s}};
  endfunction : rc_add
  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    n_fail = 0;
    checks = 0;
    reset = 1'h1;
    apb_req = '0;
    fire = 8'h00;
    repeat (4) @(posedge clk_sys);
    reset <= 1'h0;
    @(posedge clk_sys);
    rdchk("result", dab_pkg::REG_RESULT, 32'h0);
    wr(8'h80, 32'hffff_ffff);
    rdchk("unmapped", 8'h80, 32'h0);
    wr(dab_pkg::REG_OPA, 32'h8000_0f04);
    wr(dab_pkg::REG_OPB, 32'hf0f0_1234);
    for (i = 1; i <= 6; i++)
    begin
      ex = ref_op(i, 32'h8000_0f04, 32'hf0f0_1234);
      run_op(4'(i), 32'h0);
      rdchk("result", dab_pkg::REG_RESULT, ex);
      rdchk("flags", dab_pkg::REG_FLAGS, {30'h0, ex[31], ex == 32'h0});
    end
    $display("test logic done");
    q = ex;
    wr(dab_pkg::REG_OPA, 32'h8000_0000);
    wr(dab_pkg::REG_OPB, 32'hffff_ff00);
    run_op(4'h7, 32'h0);
    rdchk("flags", dab_pkg::REG_FLAGS, 32'h2);
    rdchk("result", dab_pkg::REG_RESULT, q);
    run_op(4'h8, 32'h0);
    rdchk("result", dab_pkg::REG_RESULT, 32'h8000_0000);
    wr(dab_pkg::REG_OPA, 32'h0000_00ff);
    run_op(4'h7, 32'h0);
    rdchk("flags", dab_pkg::REG_FLAGS, 32'h1);
    run_op(4'h8, 32'h0);
    rdchk("result", dab_pkg::REG_RESULT, 32'h8000_0000);
    $display("test test and load done");
    for (i = 0; i < 2; i++)
    begin
      wr(dab_pkg::REG_OPA, dd[i]);
      wr(dab_pkg::REG_OPB, 32'h0);
      run_op(4'h2, 32'h0);
      wr(dab_pkg::REG_OPA, dr[i] << sh[i]);
      run_op(4'h9, 32'(sh[i]));
      ex = ((dd[i] % dr[i]) << (sh[i] + 1)) | (dd[i] / dr[i]);
      rdchk("divide", dab_pkg::REG_RESULT, ex);
    end
    $display("test divide done");
    wr(dab_pkg::REG_AUX0, 32'h0000_1000);
    wr(dab_pkg::REG_INDEX0, 32'h0000_0100);
    ex = 32'h0000_1000;
    for (i = 0; i < 511; i++)
      ex = rc_add(ex, 32'h0000_0100);
    run_op(4'ha, 32'h0000_01fe);
    rdchk("aux0", dab_pkg::REG_AUX0, ex);
    wr(dab_pkg::REG_OPA, 32'h0000_4a5c);
    run_op(4'hb, 32'h0);
    rdchk("call", dab_pkg::REG_CALLTGT, 32'h0000_4a5c);
    $display("test address done");
    fire <= 8'h04;
    @(posedge clk_sys);
    fire <= 8'h00;
    repeat (3) @(posedge clk_sys);
    rdchk("iflag", dab_pkg::REG_IFLAG, 32'h4);
    `CHK("irq", 1'h0, irq)
    wr(dab_pkg::REG_IMASK, 32'h4);
    wr(dab_pkg::REG_CTRL, 32'h0000_0010);
    rdchk("imask", dab_pkg::REG_IMASK, 32'h4);
    `CHK("irq", 1'h1, irq)
    wr(dab_pkg::REG_IFLAG, 32'h4);
    rdchk("iflag", dab_pkg::REG_IFLAG, 32'h0);
    `CHK("irq", 1'h0, irq)
    $display("test interrupt done");
    wr(dab_pkg::REG_CTRL, 32'h0000_000c);
    xfer(1'h0, dab_pkg::REG_STATUS, 32'h0);
    `CHK("state", 2'h2, rd[1:0])
    rdchk("resume", dab_pkg::REG_RESUME, 32'h0);
    `CHK("halted", 1'h1, halted)
    fire <= 8'h01;
    @(posedge clk_sys);
    fire <= 8'h00;
    for (i = 0; i < 20 && halted !== 1'h0; i++)
      @(posedge clk_sys);
    if (i >= 20)
      stall();
    rdchk("resume", dab_pkg::REG_RESUME, 32'h1);
    $display("test wait done");
    test_done();
  end
endmodule : tb_dsp_alu_divide_step_and_bitrev
